// ===== hw/evt_status.sv
// sticky event status with enable gating onto one interrupt line
`include "ext_int_defs.svh"

module evt_status (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // events from the latch core
  latch_link_if.stat_mp link,
  // software access
  input wire logic clr_we,
  input wire logic [`NUM_EVT-1:0] clr_data,
  input wire logic en_we,
  input wire logic [`NUM_EVT-1:0] en_data,
  // state and interrupt
  output logic [`NUM_EVT-1:0] status_q,
  output logic [`NUM_EVT-1:0] en_q,
  output logic irq
);
  genvar i;

  // per event: write one clears, a new event in the same cycle wins
  generate
    for (i = 0; i < `NUM_EVT; i++) begin : g_evt
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          status_q[i] <= 1'b0;
        end else if (link.evt[i]) begin
          status_q[i] <= 1'b1;
        end else if (clr_we && clr_data[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // enable register, one means the event reaches irq
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_q <= '0;
    end else if (en_we) begin
      en_q <= en_data;
    end
  end

  assign irq = |(status_q & en_q);
endmodule : evt_status

// ===== hw/ext_int_defs.svh
// constants for the external interrupt latch block
`ifndef EXT_INT_DEFS_SVH
`define EXT_INT_DEFS_SVH

// register byte offsets on the apb bus
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004
`define OFS_EN 12'h008
`define OFS_PIN 12'h00C
`define ADDR_W 12

// bit positions in the control and status register
`define BIT_MODE 0
`define BIT_MASK 1
`define BIT_ACK 2
`define BIT_FLAG 3

// bit positions of the sticky event status
`define EVT_NEW 0
`define EVT_CLR 1
`define NUM_EVT 2

// vector location fetched by the cpu for this request
`define VEC_ADDR_HI 16'hFFFA
`define VEC_ADDR_LO 16'hFFFB

// reset values
`define PIN_IDLE 1'b1
`define RST_ZERO 32'h0000_0000
`endif

// ===== hw/ext_int_pkg.sv
// shared types of the external interrupt latch block
`include "ext_int_defs.svh"

package ext_int_pkg;
  // one bit per sticky event
  typedef logic [`NUM_EVT-1:0] evt_t;

  // level mode clear tracking
  typedef enum logic {
    ACK_IDLE,
    ACK_WAIT_HIGH
  } ack_state_t;
endpackage : ext_int_pkg

// ===== hw/external_interrupt_latch.sv
// external interrupt latch with apb registers, mask and event interrupt
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "ext_int_defs.svh"

module external_interrupt_latch (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external pin
  input wire logic irq_pin_n,
  // cpu side
  input wire logic vec_fetch,
  output logic cpu_int_req,
  output logic pin_level,
  output logic [15:0] vec_addr_hi,
  output logic [15:0] vec_addr_lo,
  // event interrupt
  output logic irq
);
  latch_link_if link ();

  logic ext_request_latch_q;
  logic ext_request_latch_d;
  logic edge_level_select_q;
  logic int_mask_bit_q;
  ext_int_pkg::ack_state_t ack_st_q;
  logic [31:0] prdata_q;
  logic [`NUM_EVT-1:0] status_q;
  logic [`NUM_EVT-1:0] en_q;
  logic wr_acc;
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_en;
  logic hit_pin;
  logic mapped;
  logic sw_ack;
  logic fetch_ack;
  logic any_ack;
  logic set_req;
  logic clr_req;
  logic [31:0] rd_mux;

  // pin synchroniser and edge detect
  pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .irq_pin_n(irq_pin_n),
    .link(link.sync_mp)
  );

  // address decode
  assign hit_ctrl = (paddr == `OFS_CTRL);
  assign hit_stat = (paddr == `OFS_STAT);
  assign hit_en = (paddr == `OFS_EN);
  assign hit_pin = (paddr == `OFS_PIN);
  assign mapped = hit_ctrl | hit_stat | hit_en | hit_pin;

  // zero wait slave: writes land on the access edge
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite & pstrb[0] & mapped;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // acknowledge sources; a fetch only acks a request that is latched
  assign sw_ack = wr_acc & hit_ctrl & pwdata[`BIT_ACK];
  assign fetch_ack = vec_fetch & ext_request_latch_q;
  assign any_ack = sw_ack | fetch_ack;

  // level mode keeps the request up for as long as the pin stays low
  assign set_req = link.fall | (edge_level_select_q & ~link.pin_level);

  // clear: at once in edge mode, in level mode only once the pin is high
  always_comb begin
    clr_req = 1'b0;
    if (!edge_level_select_q) begin
      clr_req = any_ack;
    end else begin
      clr_req = link.pin_level & (any_ack | (ack_st_q == ext_int_pkg::ACK_WAIT_HIGH));
    end
  end

  // set wins so an edge right after an ack is never lost
  assign ext_request_latch_d = set_req | (ext_request_latch_q & ~clr_req);

  // request latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_request_latch_q <= 1'b0;
    end else begin
      ext_request_latch_q <= ext_request_latch_d;
    end
  end

  // remembers an ack taken while the pin was still low in level mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_st_q <= ext_int_pkg::ACK_IDLE;
    end else begin
      case (ack_st_q)
        ext_int_pkg::ACK_IDLE: begin
          if (edge_level_select_q && any_ack && !link.pin_level) begin
            ack_st_q <= ext_int_pkg::ACK_WAIT_HIGH;
          end
        end
        ext_int_pkg::ACK_WAIT_HIGH: begin
          // leaving level mode or the clear itself ends the wait
          if (!ext_request_latch_d || !edge_level_select_q) begin
            ack_st_q <= ext_int_pkg::ACK_IDLE;
          end
        end
        default: begin
          ack_st_q <= ext_int_pkg::ACK_IDLE;
        end
      endcase
    end
  end

  // mode and mask bits; the ack bit has no storage at all
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      edge_level_select_q <= 1'b0;
      int_mask_bit_q <= 1'b0;
    end else if (wr_acc && hit_ctrl) begin
      edge_level_select_q <= pwdata[`BIT_MODE];
      int_mask_bit_q <= pwdata[`BIT_MASK];
    end
  end

  // request to cpu priority logic; the cpu's own global mask is outside
  assign cpu_int_req = ext_request_latch_q & ~int_mask_bit_q;

  // latch events feed the sticky status
  assign link.evt[`EVT_NEW] = ext_request_latch_d & ~ext_request_latch_q;
  assign link.evt[`EVT_CLR] = ext_request_latch_q & ~ext_request_latch_d;

  evt_status u_stat (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .link(link.stat_mp),
    .clr_we(wr_acc & hit_stat),
    .clr_data(pwdata[`NUM_EVT-1:0]),
    .en_we(wr_acc & hit_en),
    .en_data(pwdata[`NUM_EVT-1:0]),
    .status_q(status_q),
    .en_q(en_q),
    .irq(irq)
  );

  // read mux; ack bit always reads zero, unmapped reads zero
  always_comb begin
    rd_mux = `RST_ZERO;
    if (hit_ctrl) begin
      rd_mux[`BIT_MODE] = edge_level_select_q;
      rd_mux[`BIT_MASK] = int_mask_bit_q;
      rd_mux[`BIT_ACK] = 1'b0;
      rd_mux[`BIT_FLAG] = ext_request_latch_q;
    end else if (hit_stat) begin
      rd_mux[`NUM_EVT-1:0] = status_q;
    end else if (hit_en) begin
      rd_mux[`NUM_EVT-1:0] = en_q;
    end else if (hit_pin) begin
      rd_mux[0] = link.pin_level;
    end
  end

  // read data captured in setup so it stands through the access cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_q <= `RST_ZERO;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end
  assign prdata = prdata_q;

  // pin level and vector addresses towards the cpu
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vec_addr_hi <= `VEC_ADDR_HI;
      vec_addr_lo <= `VEC_ADDR_LO;
      pin_level <= `PIN_IDLE;
    end else begin
      vec_addr_hi <= `VEC_ADDR_HI;
      vec_addr_lo <= `VEC_ADDR_LO;
      pin_level <= link.pin_level;
    end
  end

  // checks on the latch, the register file and the cpu outputs
  // reset is a plain synchronous level, so every check except AST_RESET_CLEARS pauses while it is low
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  AST_SET_ON_FALL: assert property (link.fall |=> ext_request_latch_q)
    else $error("falling edge did not set the latch");

  AST_FETCH_CLEARS: assert property (
    !edge_level_select_q && fetch_ack && !set_req |=> !ext_request_latch_q)
    else $error("vector fetch did not clear the latch");

  AST_SW_ACK_CLEARS: assert property (
    !edge_level_select_q && sw_ack && !set_req |=> !ext_request_latch_q)
    else $error("software ack did not clear the latch");

  AST_RESET_CLEARS: assert property (
    @(posedge sys_clk) disable iff (1'b0) !rst_n |=> !ext_request_latch_q && !edge_level_select_q
      && !int_mask_bit_q)
    else $error("reset left latch or control bits set");

  AST_LEVEL_HOLDS: assert property (
    edge_level_select_q && ext_request_latch_q && !link.pin_level |=> ext_request_latch_q)
    else $error("level mode latch cleared while pin low");

  AST_LEVEL_LATE_CLEAR: assert property (
    edge_level_select_q && ack_st_q == ext_int_pkg::ACK_WAIT_HIGH && link.pin_level |=> !ext_request_latch_q)
    else $error("level mode latch not cleared once pin rose");

  AST_MASK_GATES: assert property (
    cpu_int_req |-> ext_request_latch_q && !int_mask_bit_q)
    else $error("masked or absent request reached the cpu");

  AST_REQ_PASSES: assert property (
    $rose(ext_request_latch_q) && !int_mask_bit_q |-> cpu_int_req)
    else $error("unmasked request not passed to the cpu");

  AST_ACK_READS_ZERO: assert property (
    setup && !pwrite && hit_ctrl |=> prdata[`BIT_ACK] == 1'b0)
    else $error("ack bit read as one");

  AST_FLAG_READ: assert property (
    setup && !pwrite && hit_ctrl |=> prdata[`BIT_FLAG] == $past(ext_request_latch_q))
    else $error("event flag does not match the latch");

  AST_PIN_TO_CPU: assert property (
    $fell(link.pin_level) |=> !pin_level)
    else $error("pin level not passed to the cpu");

  // edge mode: nothing but a fresh fall may set the latch
  AST_EDGE_ONLY: assert property (
    !edge_level_select_q && !ext_request_latch_q && !link.fall |=> !ext_request_latch_q)
    else $error("latch set in edge mode without a falling edge");

  // level mode: a low pin keeps the request pending
  AST_LEVEL_LOW_SETS: assert property (edge_level_select_q && !link.pin_level |=> ext_request_latch_q)
    else $error("low pin in level mode left the latch clear");

  // the mask only gates the cpu path, the latch still catches edges
  AST_MASK_KEEPS_LATCH: assert property (int_mask_bit_q && link.fall |=> ext_request_latch_q)
    else $error("masked falling edge was not latched");

  // a write with the low byte strobe off must leave the control bits alone
  AST_STRB_IGNORED: assert property (
    psel && penable && pwrite && !pstrb[0] |=> $stable(int_mask_bit_q) && $stable(edge_level_select_q))
    else $error("write without low byte strobe changed the control bits");

  AST_VEC_FIXED: assert property (vec_addr_hi == `VEC_ADDR_HI && vec_addr_lo == `VEC_ADDR_LO)
    else $error("vector addresses changed");

  AST_PIN_READ: assert property (
    setup && !pwrite && hit_pin |=> prdata[0] == $past(link.pin_level))
    else $error("pin level read back wrong");

  // status events follow the latch edges, a clear in the same cycle loses
  AST_STATUS_NEW: assert property ($rose(ext_request_latch_q) |-> status_q[`EVT_NEW])
    else $error("new request not recorded in status");

  AST_STATUS_CLR: assert property ($fell(ext_request_latch_q) |-> status_q[`EVT_CLR])
    else $error("latch clear not recorded in status");

  // scenarios the bench should reach
  COV_EDGE_ACK: cover property (link.fall ##[1:20] sw_ack);
  COV_FETCH: cover property (cpu_int_req ##[1:20] fetch_ack);
  COV_LEVEL_WAIT: cover property (ack_st_q == ext_int_pkg::ACK_WAIT_HIGH ##[1:50] !ext_request_latch_q);
  COV_IRQ: cover property ($rose(irq));
  COV_MASKED_LATCH: cover property (int_mask_bit_q && $rose(ext_request_latch_q));
endmodule : external_interrupt_latch

// ===== hw/latch_link_if.sv
// carrier between the pin synchroniser, the latch core and the status block
`include "ext_int_defs.svh"

interface latch_link_if;
  logic pin_level;
  logic fall;
  ext_int_pkg::evt_t evt;

  modport sync_mp (output pin_level, output fall);
  modport core_mp (input pin_level, input fall, output evt);
  modport stat_mp (input evt);
endinterface : latch_link_if

// ===== hw/pin_sync.sv
// two flop synchroniser and falling edge detect for the interrupt pin
`include "ext_int_defs.svh"

module pin_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // raw active low pin
  input wire logic irq_pin_n,
  // synchronised level and edge
  latch_link_if.sync_mp link
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // meta_q is read only by sync_q; idle level is high so reset fakes no edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= `PIN_IDLE;
      sync_q <= `PIN_IDLE;
      prev_q <= `PIN_IDLE;
    end else begin
      meta_q <= irq_pin_n;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edge from the two synchronised samples only
  assign link.fall = prev_q & ~sync_q;
  assign link.pin_level = sync_q;
endmodule : pin_sync

// ===== testbench/external_interrupt_latch_tb.sv
// self-checking bench for the external interrupt latch
`include "ext_int_defs.svh"

module external_interrupt_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] ctrl_a = `OFS_CTRL;
  localparam logic [11:0] stat_a = `OFS_STAT;
  localparam logic [11:0] en_a = `OFS_EN;
  localparam logic [11:0] pin_a = `OFS_PIN;
  localparam logic [31:0] md = 32'h1 << `BIT_MODE;
  localparam logic [31:0] mk = 32'h1 << `BIT_MASK;
  localparam logic [31:0] ak = 32'h1 << `BIT_ACK;
  localparam logic [31:0] fl = 32'h1 << `BIT_FLAG;
  logic sys_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic vec_fetch;
  logic cpu_gmask;
  logic [31:0] prdata;
  logic pready, pslverr, irq_pin_n, cpu_int_req, pin_level, irq;
  logic [15:0] vec_hi, vec_lo;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  external_interrupt_latch dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_pin_n(irq_pin_n), .vec_fetch(vec_fetch), .cpu_int_req(cpu_int_req),
    .pin_level(pin_level), .vec_addr_hi(vec_hi), .vec_addr_lo(vec_lo), .irq(irq));

  irq_source src_u (.sys_clk(sys_clk), .irq_pin_n(irq_pin_n));

  task automatic tally_and_finish();
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // hang guard, the whole sequence needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  // read and compare; only the four low word addresses are mapped
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
    chk(32'(e), 32'(a > pin_a));
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle

  // one-cycle vector fetch strobe; the cpu only services a request it sees with its global mask clear
  task automatic fetch();
    @(posedge sys_clk);
    vec_fetch <= cpu_int_req & ~cpu_gmask;
    @(posedge sys_clk);
    vec_fetch <= 1'b0;
  endtask : fetch

  // main sequence
  initial begin
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    pstrb <= 4'hF;
    vec_fetch <= 1'b0;
    cpu_gmask <= 1'b0;
    idle(20);
    rst_n <= 1'b1;
    rd(ctrl_a, 32'h0);
    rd(stat_a, 32'h0);
    rd(en_a, 32'h0);
    rd(pin_a, 32'h1);
    wr(ctrl_a, md | mk | ak);
    rd(ctrl_a, md | mk);
    // a write without the low byte strobe must be ignored
    pstrb <= 4'hE;
    wr(ctrl_a, 32'h0);
    pstrb <= 4'hF;
    rd(ctrl_a, md | mk);
    wr(ctrl_a, 32'h0);
    wr(en_a, 32'h3);
    src_u.set_pin(1'b0);
    idle(6);
    chk(32'(pin_level), 32'h0);
    rd(pin_a, 32'h0);
    rd(ctrl_a, fl);
    chk(32'(cpu_int_req), 32'h1);
    chk(32'(irq), 32'h1);
    rd(stat_a, 32'h1);
    // software ack while the pin is still low clears at once in edge mode
    wr(ctrl_a, ak);
    rd(ctrl_a, 32'h0);
    rd(stat_a, 32'h3);
    wr(stat_a, 32'h3);
    rd(stat_a, 32'h0);
    chk(32'(irq), 32'h0);
    src_u.set_pin(1'b1);
    idle(6);
    rd(ctrl_a, 32'h0);
    src_u.set_pin(1'b0);
    idle(6);
    rd(ctrl_a, fl);
    fetch();
    idle(2);
    rd(ctrl_a, 32'h0);
    chk({vec_hi, vec_lo}, 32'hFFFA_FFFB);
    src_u.set_pin(1'b1);
    wr(en_a, 32'h0);
    wr(ctrl_a, mk);
    src_u.set_pin(1'b0);
    idle(6);
    rd(ctrl_a, mk | fl);
    chk(32'(cpu_int_req), 32'h0);
    chk(32'(irq), 32'h0);
    wr(ctrl_a, 32'h0);
    idle(1);
    chk(32'(cpu_int_req), 32'h1);
    // cpu global mask set: no service, the request stays latched
    cpu_gmask <= 1'b1;
    fetch();
    rd(ctrl_a, fl);
    cpu_gmask <= 1'b0;
    fetch();
    src_u.set_pin(1'b1);
    wr(stat_a, 32'h3);
    // level mode, acknowledge first then pin release
    wr(ctrl_a, md);
    src_u.set_pin(1'b0);
    idle(6);
    wr(ctrl_a, md | ak);
    idle(2);
    rd(ctrl_a, md | fl);
    fetch();
    idle(2);
    rd(ctrl_a, md | fl);
    src_u.set_pin(1'b1);
    idle(6);
    rd(ctrl_a, md);
    // level mode, pin release first then acknowledge
    src_u.set_pin(1'b0);
    idle(6);
    src_u.set_pin(1'b1);
    idle(6);
    rd(ctrl_a, md | fl);
    wr(ctrl_a, md | ak);
    idle(1);
    rd(ctrl_a, md);
    rd(12'h010, 32'h0);
    // reset in mid-run with a request latched
    src_u.set_pin(1'b0);
    idle(6);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    src_u.set_pin(1'b1);
    idle(4);
    rst_n <= 1'b1;
    idle(4);
    rd(ctrl_a, 32'h0);
    chk(32'(cpu_int_req), 32'h0);
    tally_and_finish();
  end
endmodule : external_interrupt_latch_tb

// ===== testbench/irq_source.sv
// model of the outside device that pulls the active low interrupt line
module irq_source (
  // bench clock
  input wire logic sys_clk,
  // line towards the block, pulled up when released
  output logic irq_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // released line idles high through its pull-up
  initial irq_pin_n = 1'b1;

  // level changes just after an edge; the block itself treats the line as async
  task automatic set_pin(input logic lvl);
    @(posedge sys_clk);
    irq_pin_n <= lvl;
  endtask : set_pin
endmodule : irq_source
